// ===== hw/wdrst_consts.svh
`ifndef WDRST_CONSTS_SVH
`define WDRST_CONSTS_SVH
`define WDRST_ADDR_CTRL        8'h00
`define WDRST_ADDR_SERVICE     8'h04
`define WDRST_ADDR_INSTR       8'h08
`define WDRST_ADDR_STATUS      8'h0c
`define WDRST_CTRL_PRESCALE    0
`define WDRST_CTRL_DISABLE     1
`define WDRST_CTRL_BDRST       2
`define WDRST_CTRL_RELOAD_LO   8
`define WDRST_INSTR_EOI        0
`define WDRST_INSTR_SWRST      1
`define WDRST_FLAG_WDT         0
`define WDRST_FLAG_SW          1
`define WDRST_FLAG_SHORT       2
`define WDRST_FLAG_LONG        3
`define WDRST_FLAG_PON         4
`define WDRST_STAT_EOI_DONE    8
`define WDRST_STAT_ENABLED     9
`define WDRST_STAT_IN_RESET    10
`define WDRST_DIV_FAST         7'h01
`define WDRST_DIV_SLOW         7'h7f
`define WDRST_CLK_MHZ          20
`define WDRST_FILT_MIN_NS      500
`define WDRST_FILT_CYC         ((`WDRST_FILT_MIN_NS * `WDRST_CLK_MHZ) / 1000)
`define WDRST_SPIKE_NS         50
`define WDRST_LONG_TCL         1044
`define WDRST_LONG_CYC         ((`WDRST_LONG_TCL + 1) / 2)
`define WDRST_RST_HOLD_CYC     4
`endif

// ===== hw/wdrst_filter.sv
`timescale 1ns/1ps
`include "wdrst_consts.svh"
module wdrst_filter
#(
    parameter int unsigned LEN = 10
)
(
    input  wire logic i_clk_sys,
    input  wire logic i_rst_b,
    input  wire logic i_pin,
    output logic      o_low
);
    logic [1:0]  sync_q;
    logic [15:0] cnt_q;

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_b)
            sync_q <= 2'h3;
        else
            sync_q <= {sync_q[0], i_pin};
    end

    // Low must persist LEN cycles; shorter spikes die here
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_b)
        begin
            cnt_q <= 16'h0000;
            o_low <= 1'b0;
        end
        else if (sync_q[1])
        begin
            cnt_q <= 16'h0000;
            o_low <= 1'b0;
        end
        else if (cnt_q < 16'(LEN - 1))
            cnt_q <= cnt_q + 16'h0001;
        else
            o_low <= 1'b1;
    end
endmodule

// ===== hw/wdrst_pkg.sv
package wdrst_pkg;
    typedef enum logic [3:0] {
        WDRST_RUN      = 4'b0001,
        WDRST_SYNC_RST = 4'b0010,
        WDRST_ASYNC    = 4'b0100,
        WDRST_RELEASE  = 4'b1000
    } wdrst_state_t;
    typedef logic [4:0] wdrst_flags_t;
endpackage

// ===== hw/wdrst_top.sv
`timescale 1ns/1ps
`include "wdrst_consts.svh"
module wdrst_top
#(
    parameter int unsigned LONG_CYC = `WDRST_LONG_CYC
)
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_b,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic             o_pready,
    output logic [31:0]      o_prdata,
    output logic             o_pslverr,
    input  wire logic        i_reset_input_pin,
    input  wire logic        i_reset_mode_pin,
    input  wire logic        i_power_on,
    output logic             o_reset_input_pin_out,
    output logic             o_reset_input_pin_oe,
    output logic             o_reset_output_pin_b,
    output logic             o_internal_reset,
    output logic             o_async_reset,
    output logic             o_watchdog_count_msb
);
    import wdrst_pkg::*;

    logic               filt_low;
    logic [1:0]         mode_sync_q;
    logic               mode_low;
    logic [1:0]         pon_sync_q;
    wdrst_state_t       state_q;
    logic [15:0]        wdt_q;
    logic [6:0]         pre_q;
    logic               tick;
    logic               prescale_q;
    logic               disable_q;
    logic               bdrst_q;
    logic [7:0]         reload_q;
    logic               eoi_done_q;
    wdrst_flags_t       flags_q;
    logic [15:0]        low_cnt_q;
    logic               was_low_q;
    logic [2:0]         hold_q;
    logic               wr;
    logic               rd;
    logic               overflow;
    logic               do_service;
    logic               do_eoi;
    logic               do_swrst;
    logic               ctrl_wr;
    logic               hw_release;
    logic               pulse_short;
    logic               pulse_long;

    wdrst_filter #(
        .LEN (`WDRST_FILT_CYC)
    ) u_filter (
        .i_clk_sys (i_clk_sys),
        .i_rst_b   (i_rst_b),
        .i_pin     (i_reset_input_pin),
        .o_low     (filt_low)
    );

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_b)
        begin
            mode_sync_q <= 2'h3;
            pon_sync_q  <= 2'h0;
        end
        else
        begin
            mode_sync_q <= {mode_sync_q[0], i_reset_mode_pin};
            pon_sync_q  <= {pon_sync_q[0], i_power_on};
        end
    end
    assign mode_low = ~mode_sync_q[1];

    assign wr         = i_psel && i_penable && i_pwrite && o_pready;
    assign rd         = i_psel && !i_penable && !i_pwrite;
    assign ctrl_wr    = wr && (i_paddr == `WDRST_ADDR_CTRL);
    assign do_service = wr && (i_paddr == `WDRST_ADDR_SERVICE) && (state_q == WDRST_RUN);
    assign do_eoi     = wr && (i_paddr == `WDRST_ADDR_INSTR)
                        && i_pwdata[`WDRST_INSTR_EOI] && (state_q == WDRST_RUN);
    assign do_swrst   = wr && (i_paddr == `WDRST_ADDR_INSTR)
                        && i_pwdata[`WDRST_INSTR_SWRST] && (state_q == WDRST_RUN);
    assign tick       = (pre_q == (prescale_q ? `WDRST_DIV_SLOW : `WDRST_DIV_FAST));
    assign overflow   = tick && (wdt_q == 16'hffff) && !disable_q && (state_q == WDRST_RUN);
    assign hw_release = was_low_q && !filt_low && !mode_low;
    assign pulse_long  = hw_release && (low_cnt_q >= 16'(LONG_CYC));
    assign pulse_short = hw_release && (low_cnt_q < 16'(LONG_CYC));

    // APB answers in the access cycle, no wait states
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_b)
        begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end
        else
        begin
            o_pready  <= i_psel && !i_penable;
            o_pslverr <= i_psel && !i_penable && (i_paddr > `WDRST_ADDR_STATUS);
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_b)
            o_prdata <= 32'h00000000;
        else if (rd)
        begin
            case (i_paddr)
                `WDRST_ADDR_CTRL:
                    o_prdata <= {16'h0000, reload_q, 5'h00, bdrst_q, disable_q, prescale_q};
                `WDRST_ADDR_SERVICE:
                    o_prdata <= {16'h0000, wdt_q};
                `WDRST_ADDR_STATUS:
                    o_prdata <= {21'h000000, (state_q != WDRST_RUN), !disable_q,
                                 eoi_done_q, 3'h0, flags_q};
                default:
                    o_prdata <= 32'h00000000;
            endcase
        end
    end

    // Control fields; disable refused once init is over
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_b || state_q != WDRST_RUN)
        begin
            prescale_q <= 1'b0;
            disable_q  <= 1'b0;
            bdrst_q    <= 1'b0;
            reload_q   <= 8'h00;
        end
        else if (ctrl_wr)
        begin
            prescale_q <= i_pwdata[`WDRST_CTRL_PRESCALE];
            bdrst_q    <= i_pwdata[`WDRST_CTRL_BDRST];
            reload_q   <= i_pwdata[`WDRST_CTRL_RELOAD_LO +: 8];
            if (!eoi_done_q)
                disable_q <= i_pwdata[`WDRST_CTRL_DISABLE];
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_b || state_q != WDRST_RUN)
            eoi_done_q <= 1'b0;
        else if (do_eoi)
            eoi_done_q <= 1'b1;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_b || state_q != WDRST_RUN || tick)
            pre_q <= 7'h00;
        else
            pre_q <= pre_q + 7'h01;
    end

    // Counter; timeout (256-reload)*256*(div+1)
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_b || state_q != WDRST_RUN)
            wdt_q <= 16'h0000;
        else if (do_service)
            wdt_q <= {reload_q, 8'h00};
        else if (tick && !disable_q)
            wdt_q <= wdt_q + 16'h0001;
    end

    // Flags survive the chip reset they describe; end-of-init and i_rst_b clear them
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_b)
            flags_q <= 5'h00;
        else if (pon_sync_q[1] && mode_low)
            flags_q <= 5'h10;
        else if (overflow)
            flags_q <= 5'h01;
        else if (do_swrst)
            flags_q <= 5'h02;
        else if (pulse_long)
            flags_q <= 5'h08;
        else if (pulse_short)
            flags_q <= 5'h04;
        else if (do_eoi)
            flags_q <= 5'h00;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_b)
        begin
            low_cnt_q <= 16'h0000;
            was_low_q <= 1'b0;
        end
        else
        begin
            was_low_q <= filt_low && !mode_low;
            if (!filt_low)
                low_cnt_q <= 16'h0000;
            else if (low_cnt_q != 16'hffff)
                low_cnt_q <= low_cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_b)
        begin
            state_q <= WDRST_RUN;
            hold_q  <= 3'h0;
        end
        else
        begin
            case (state_q)
                WDRST_RUN:
                begin
                    hold_q <= 3'h0;
                    if (filt_low && mode_low)
                        state_q <= WDRST_ASYNC;
                    else if (overflow || do_swrst || (filt_low && !mode_low))
                        state_q <= WDRST_SYNC_RST;
                end
                WDRST_SYNC_RST:
                begin
                    hold_q <= hold_q + 3'h1;
                    if (filt_low && mode_low)
                        state_q <= WDRST_ASYNC;
                    else if (!filt_low && hold_q >= 3'(`WDRST_RST_HOLD_CYC))
                        state_q <= WDRST_RELEASE;
                end
                WDRST_ASYNC:
                    if (!filt_low)
                        state_q <= WDRST_RELEASE;
                WDRST_RELEASE:
                    state_q <= WDRST_RUN;
                default:
                    state_q <= WDRST_RUN;
            endcase
        end
    end

    // Reset pins; bidirectional drive inhibited by mode pin low
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_b)
        begin
            o_reset_output_pin_b  <= 1'b0;
            o_internal_reset      <= 1'b1;
            o_async_reset         <= 1'b0;
            o_reset_input_pin_out <= 1'b0;
            o_reset_input_pin_oe  <= 1'b0;
            o_watchdog_count_msb  <= 1'b0;
        end
        else
        begin
            o_reset_output_pin_b  <= (state_q == WDRST_RUN);
            o_internal_reset      <= (state_q != WDRST_RUN);
            o_async_reset         <= (state_q == WDRST_ASYNC);
            o_reset_input_pin_out <= 1'b0;
            o_reset_input_pin_oe  <= (state_q == WDRST_SYNC_RST) && bdrst_q
                                     && !mode_low && !filt_low;
            o_watchdog_count_msb  <= wdt_q[15];
        end
    end

    property p_disable_locked;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        eoi_done_q && !disable_q |=> !disable_q;
    endproperty
    a_disable_locked: assert property (p_disable_locked) else $error("disable after init");

    property p_overflow_reset;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        overflow |=> ##1 !o_reset_output_pin_b && o_internal_reset;
    endproperty
    a_overflow_reset: assert property (p_overflow_reset) else $error("no reset on overflow");

    property p_wdt_flag;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        overflow && !(pon_sync_q[1] && mode_low) |=> flags_q == 5'h01;
    endproperty
    a_wdt_flag: assert property (p_wdt_flag) else $error("watchdog flag missing");

    property p_eoi_clear;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        do_eoi && !overflow && !do_swrst && !hw_release && !pon_sync_q[1] |=> flags_q == 5'h00;
    endproperty
    a_eoi_clear: assert property (p_eoi_clear) else $error("flags not cleared");

    property p_step;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        tick && !disable_q && !do_service && state_q == WDRST_RUN && wdt_q != 16'hffff
        |=> wdt_q == $past(wdt_q) + 16'h0001;
    endproperty
    a_step: assert property (p_step) else $error("counter step wrong");

    property p_service;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        do_service |=> wdt_q == {$past(reload_q), 8'h00};
    endproperty
    a_service: assert property (p_service) else $error("service load wrong");

    property p_async;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        state_q == WDRST_RUN && filt_low && mode_low |=> state_q == WDRST_ASYNC ##1 o_async_reset;
    endproperty
    a_async: assert property (p_async) else $error("async reset missed");

    property p_no_drive;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        mode_low |=> !o_reset_input_pin_oe;
    endproperty
    a_no_drive: assert property (p_no_drive) else $error("drives pin in mode low");

    c_overflow: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) overflow);
    c_long: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) pulse_long);
    c_short: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) pulse_short);
    c_swrst: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) do_swrst);
endmodule

// ===== verification/wdrst_top_test.sv
`timescale 1ns/1ps
`include "wdrst_consts.svh"
module watchdog_and_reset_source_control_test;
    import wdrst_pkg::*;
    localparam int unsigned LONG_CYC = 20;
    logic        i_clk_sys         = 1'b0;
    logic        i_rst_b           = 1'b0;
    logic        i_psel            = 1'b0;
    logic        i_penable         = 1'b0;
    logic        i_pwrite          = 1'b0;
    logic [7:0]  i_paddr           = 8'h00;
    logic [31:0] i_pwdata          = 32'h0;
    logic        i_reset_mode_pin  = 1'b1;
    logic        i_power_on        = 1'b0;
    logic        ext_b             = 1'b1;
    int          rst_lows          = 0;
    int          rst_mark          = 0;
    logic        o_pready;
    logic [31:0] o_prdata;
    logic        o_pslverr;
    logic        o_reset_input_pin_out;
    logic        o_reset_input_pin_oe;
    logic        o_reset_output_pin_b;
    logic        o_internal_reset;
    logic        o_async_reset;
    logic        o_watchdog_count_msb;
    logic [31:0] rdata;
    logic        rerr;
    wire logic   rst_pin;
    int          fails        = 0;
    int          total_checks = 0;
    int          n;
    // Open-drain reset pin with pull-up: the device only ever pulls low
    assign rst_pin = ext_b & (~o_reset_input_pin_oe | o_reset_input_pin_out);
    wdrst_top #(.LONG_CYC(LONG_CYC)) u_wdrst_top (
        .i_clk_sys             (i_clk_sys),
        .i_rst_b               (i_rst_b),
        .i_psel                (i_psel),
        .i_penable             (i_penable),
        .i_pwrite              (i_pwrite),
        .i_paddr               (i_paddr),
        .i_pwdata              (i_pwdata),
        .o_pready              (o_pready),
        .o_prdata              (o_prdata),
        .o_pslverr             (o_pslverr),
        .i_reset_input_pin     (rst_pin),
        .i_reset_mode_pin      (i_reset_mode_pin),
        .i_power_on            (i_power_on),
        .o_reset_input_pin_out (o_reset_input_pin_out),
        .o_reset_input_pin_oe  (o_reset_input_pin_oe),
        .o_reset_output_pin_b  (o_reset_output_pin_b),
        .o_internal_reset      (o_internal_reset),
        .o_async_reset         (o_async_reset),
        .o_watchdog_count_msb  (o_watchdog_count_msb)
    );
    always #25 i_clk_sys = ~i_clk_sys;
    // Counted, so short reset pulses between polls are not missed
    always @(negedge i_clk_sys)
    begin
        if (o_reset_output_pin_b === 1'b0)
            rst_lows <= rst_lows + 1;
    end
    task automatic results();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge i_clk_sys);
        i_psel   <= 1'b1;
        i_pwrite <= wr;
        i_paddr  <= a;
        i_pwdata <= d;
        @(posedge i_clk_sys);
        i_penable <= 1'b1;
        k = 0;
        // Pready is looked at only as sampled on a rising edge
        do
        begin
            @(posedge i_clk_sys);
            k++;
        end
        while (o_pready !== 1'b1 && k < 20);
        if (o_pready !== 1'b1)
        begin
            fails++;
            results();
        end
        else
        begin
            rdata = o_prdata;
            rerr  = o_pslverr;
            i_psel    <= 1'b0;
            i_penable <= 1'b0;
        end
    endtask
    task automatic wait_event();
        int k;
        k = 0;
        while (!(rst_lows != rst_mark && o_reset_output_pin_b === 1'b1) && k < 400)
        begin
            @(negedge i_clk_sys);
            k++;
        end
        check("reset event", 32'h1, k < 400);
    endtask
    task automatic flag_check(input int b);
        apb(1'b0, `WDRST_ADDR_STATUS, 32'h0);
        check("status after reset", (32'h1 << b) | 32'h200, rdata & 32'h71f);
        apb(1'b1, `WDRST_ADDR_INSTR, 32'h1 << `WDRST_INSTR_EOI);
        apb(1'b0, `WDRST_ADDR_STATUS, 32'h0);
        check("flags after eoi", 32'h0, rdata & 32'h1f);
    endtask
    task automatic pulse(input int c);
        @(posedge i_clk_sys);
        ext_b <= 1'b0;
        repeat (c) @(posedge i_clk_sys);
        ext_b <= 1'b1;
    endtask
    initial
    begin
        repeat (100000) @(posedge i_clk_sys);
        fails++;
        results();
    end
    initial
    begin
        repeat (8) @(posedge i_clk_sys);
        i_rst_b <= 1'b1;
        apb(1'b0, `WDRST_ADDR_STATUS, 32'h0);
        check("status at start", 32'h200, rdata & 32'h71f);
        apb(1'b0, `WDRST_ADDR_CTRL, 32'h0);
        check("ctrl at start", 32'h0, rdata);
        apb(1'b0, 8'h10, 32'h0);
        check("unmapped error", 32'h1, rerr);
        apb(1'b1, `WDRST_ADDR_CTRL, 32'h1 << `WDRST_CTRL_DISABLE);
        apb(1'b0, `WDRST_ADDR_STATUS, 32'h0);
        check("disable before eoi", 32'h0, rdata[`WDRST_STAT_ENABLED]);
        apb(1'b1, `WDRST_ADDR_CTRL, 32'h0);
        apb(1'b1, `WDRST_ADDR_INSTR, 32'h1 << `WDRST_INSTR_EOI);
        apb(1'b1, `WDRST_ADDR_CTRL, 32'h1 << `WDRST_CTRL_DISABLE);
        apb(1'b0, `WDRST_ADDR_STATUS, 32'h0);
        check("disable after eoi", 32'h300, rdata & 32'h31f);
        // Both prescales with the shortest reload; the slow one dominates run time
        for (int p = 0; p < 2; p++)
        begin
            apb(1'b1, `WDRST_ADDR_CTRL, (32'hff << `WDRST_CTRL_RELOAD_LO) | p);
            rst_mark = rst_lows;
            apb(1'b1, `WDRST_ADDR_SERVICE, 32'h0);
            n = 0;
            apb(1'b0, `WDRST_ADDR_SERVICE, 32'h0);
            check("count high byte", 32'hff, rdata[15:8]);
            check("count low byte", 32'h1, rdata[7:0] < 8'h08);
            check("count msb", 32'h1, o_watchdog_count_msb);
            while (o_reset_output_pin_b === 1'b1 && n < 40000)
            begin
                @(negedge i_clk_sys);
                n++;
            end
            check("timeout", 32'h1, p ? (n >= 32630 && n <= 32900) : (n >= 495 && n <= 530));
            wait_event();
            flag_check(`WDRST_FLAG_WDT);
        end
        rst_mark = rst_lows;
        apb(1'b1, `WDRST_ADDR_INSTR, 32'h1 << `WDRST_INSTR_SWRST);
        wait_event();
        flag_check(`WDRST_FLAG_SW);
        rst_mark = rst_lows;
        pulse(1);
        repeat (40) @(negedge i_clk_sys);
        check("spike ignored", 32'h0, rst_lows != rst_mark);
        rst_mark = rst_lows;
        pulse(11);
        wait_event();
        flag_check(`WDRST_FLAG_SHORT);
        rst_mark = rst_lows;
        pulse(40);
        wait_event();
        flag_check(`WDRST_FLAG_LONG);
        apb(1'b1, `WDRST_ADDR_CTRL, 32'h1 << `WDRST_CTRL_BDRST);
        rst_mark = rst_lows;
        apb(1'b1, `WDRST_ADDR_INSTR, 32'h1 << `WDRST_INSTR_SWRST);
        n = 0;
        while (o_reset_input_pin_oe !== 1'b1 && n < 30)
        begin
            @(negedge i_clk_sys);
            n++;
        end
        check("bidir drives pin", 32'h1, n < 30);
        check("pin pulled low", 32'h0, rst_pin);
        wait_event();
        apb(1'b0, `WDRST_ADDR_STATUS, 32'h0);
        check("sw flag bidir", 32'h1, rdata[`WDRST_FLAG_SW]);
        apb(1'b1, `WDRST_ADDR_INSTR, 32'h1 << `WDRST_INSTR_EOI);
        @(posedge i_clk_sys);
        i_reset_mode_pin <= 1'b0;
        apb(1'b1, `WDRST_ADDR_CTRL, 32'h1 << `WDRST_CTRL_BDRST);
        rst_mark = rst_lows;
        apb(1'b1, `WDRST_ADDR_INSTR, 32'h1 << `WDRST_INSTR_SWRST);
        n = 0;
        while (o_reset_input_pin_oe !== 1'b1 && n < 30)
        begin
            @(negedge i_clk_sys);
            n++;
        end
        check("bidir inhibited", 32'h1, n == 30);
        wait_event();
        apb(1'b1, `WDRST_ADDR_INSTR, 32'h1 << `WDRST_INSTR_EOI);
        // Asynchronous reset, first plain, then as a power-on
        for (int q = 0; q < 2; q++)
        begin
            rst_mark = rst_lows;
            @(posedge i_clk_sys);
            ext_b      <= 1'b0;
            i_power_on <= q[0];
            n = 0;
            while (o_async_reset !== 1'b1 && n < 30)
            begin
                @(negedge i_clk_sys);
                n++;
            end
            check("async entry", 32'h1, n < 30);
            check("async outputs", 32'h1, !o_reset_output_pin_b && o_internal_reset);
            repeat (10) @(posedge i_clk_sys);
            ext_b      <= 1'b1;
            i_power_on <= 1'b0;
            wait_event();
        end
        flag_check(`WDRST_FLAG_PON);
        results();
    end
endmodule
